/* File: bench/spm_cpu_model.sv */
// Purpose: Core model issuing I/O and store/load strobes
// Assumes: Strobes change 2 ns after a rising edge
// Notes: Caller picks the idle gap to answer fast or slow
module spm_cpu_model
    import spm_pkg::*;
(
    input wire logic clock,
    input wire logic [7:0] io_rdata,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_addr,
    output logic [7:0] io_wdata,
    output logic spm_exec,
    output logic lpm_exec
);
    initial begin
        {io_wr, io_rd, spm_exec, lpm_exec} = '0;
        io_addr = SPM_CSR_OFFSET;
        io_wdata = 8'h00;
    end
    // Kind 0 write, 1 read, 2 store, 3 load, 4 unmapped read
    task automatic op(input int kind, input logic [7:0] v, input int gap,
                      output logic [7:0] r);
        repeat (gap + 1) @(posedge clock);
        #2;
        io_addr = (kind == 4) ? 8'h38 : SPM_CSR_OFFSET;
        io_wdata = v;
        io_wr = (kind == 0);
        io_rd = (kind == 1) || (kind == 4);
        spm_exec = (kind == 2);
        lpm_exec = (kind == 3);
        @(posedge clock);
        r = io_rdata;
        #2;
        {io_wr, io_rd, spm_exec, lpm_exec} = '0;
        io_wdata = ~v; // Released data never repeats
    endtask : op
endmodule : spm_cpu_model

/* File: bench/spm_ctrl_sva.sv */
// Purpose: Port checks for the self-program sequencer
// Assumes: Short program count in simulation
// Notes: Bound to every instance of the sequencer
module spm_ctrl_sva
    import spm_pkg::*;
#(
    parameter int PAGE_WORD_BITS = 5,
    parameter logic [15:0] HALT_START = 16'h1800,
    parameter logic [15:0] BOOT_START = 16'h1c00
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_rdata,
    input wire logic global_interrupt_flag,
    input wire logic spm_exec,
    input wire logic lpm_exec,
    input wire logic [15:0] pc_word,
    input wire logic [15:0] flash_address_pointer,
    input wire logic [15:0] data_pair,
    input wire logic lpm_override,
    input wire logic buf_wr,
    input wire logic [PAGE_WORD_BITS-1:0] buf_word,
    input wire logic [15:0] buf_data,
    input wire logic buf_clear,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [15:0] flash_page_addr,
    input wire logic cpu_halt,
    input wire logic rww_blocked,
    input wire logic spm_ready_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Any erase or write pulse
    wire logic prog = flash_write || flash_erase;
    ////////////////////////////////////////////////////////////////////////
    a_irq_gated: assert property (spm_ready_irq |-> global_interrupt_flag)
        else $error("ready irq without global enable");
    a_irq_quiet: assert property (cpu_halt || prog |-> !spm_ready_irq)
        else $error("ready irq during programming");
    a_halt_span: assert property ($rose(cpu_halt) |->
        cpu_halt [*8] ##[1:30] !cpu_halt) else $error("halt length wrong");
    a_rww_runs: assert property (prog && flash_page_addr < HALT_START
        |=> !cpu_halt && rww_blocked) else $error("rww page halted cpu");
    a_halting_section_halts: assert property (prog && flash_page_addr >= HALT_START
        |=> cpu_halt) else $error("halting page did not halt");
    a_boot_only: assert property (prog || buf_wr |-> $past(spm_exec) &&
        $past(pc_word) >= BOOT_START) else $error("store outside boot");
    a_page_align: assert property (prog |->
        flash_page_addr[PAGE_WORD_BITS:0] == '0) else $error("page addr");
    a_fill_word: assert property (buf_wr |-> buf_data == $past(data_pair)
        && buf_word == $past(flash_address_pointer[PAGE_WORD_BITS:1]))
        else $error("buffer word wrong");
    a_lpm_cause: assert property (lpm_override |-> $past(lpm_exec))
        else $error("readout without load");
    a_busy_bit: assert property (io_rd && io_addr == SPM_CSR_OFFSET
        |-> io_rdata[BIT_RWW_BUSY] == rww_blocked) else $error("busy bit");
    c_halt: cover property (prog && flash_page_addr >= HALT_START);
    c_fill: cover property (buf_wr);
    c_lpm: cover property (lpm_override);
    c_clear: cover property (buf_clear);
endmodule : spm_ctrl_sva
bind flash_self_program_ctrl spm_ctrl_sva #(.PAGE_WORD_BITS(PAGE_WORD_BITS),
    .HALT_START(HALT_START), .BOOT_START(BOOT_START)) chk (.clock, .resetn,
    .io_rd, .io_addr, .io_rdata, .global_interrupt_flag, .spm_exec,
    .lpm_exec, .pc_word, .flash_address_pointer, .data_pair, .lpm_override,
    .buf_wr, .buf_word, .buf_data, .buf_clear, .flash_erase, .flash_write,
    .flash_page_addr, .cpu_halt, .rww_blocked, .spm_ready_irq);

/* File: bench/test_flash_self_program_ctrl.sv */
// Purpose: Self-checking bench for the self-program sequencer
// Assumes: Program count shortened to 20 cycles
// Notes: Expected pulses are queued and checked by a monitor
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %0t got %h want %h", $time, g, e); end end
module test_flash_self_program_ctrl
    import spm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, resetn, io_wr, io_rd, spm_exec, lpm_exec;
    logic global_interrupt_flag, eeprom_write_busy, lpm_override, buf_wr;
    logic buf_clear, flash_erase, flash_write, cpu_halt, rww_blocked;
    logic spm_ready_irq;
    logic [7:0] io_addr, io_wdata, io_rdata, fuse_low, fuse_high, fuse_ext;
    logic [7:0] lpm_data, r;
    logic [15:0] pc_word, flash_address_pointer, data_pair, buf_data;
    logic [15:0] flash_page_addr, p;
    logic [1:0] lock_bits;
    logic [4:0] buf_word;
    logic [18:0] got, exp_q[$];
    logic [18:0] want;
    logic [31:0] seed = 32'h0001_4aa4;
    int miscompares = 0;
    int checks_done = 0;
    always #12.5 clock = ~clock;
    flash_self_program_ctrl #(.PROG_COUNT(20)) dut (.*);
    spm_cpu_model cpu (.*);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic rd(input logic [7:0] e);
        cpu.op(1, 8'h00, 0, r);
        `CHK(r, e)
    endtask : rd
    // poll enable clear before each command
    task automatic wr(input logic [7:0] v);
        int n;
        for (n = 0; n < 40; n++) begin
            cpu.op(1, 8'h00, 0, r);
            if ((r & 8'h1f) === 8'h00) break;
        end
        if (n == 40) begin
            miscompares++;
            test_done();
        end
        cpu.op(0, v, 0, r);
    endtask : wr
    // Monitor takes the oldest note per result pulse
    always @(posedge clock) begin
        #1;
        if (buf_wr | flash_write | flash_erase | lpm_override | buf_clear) begin
            got = buf_wr ? {3'd1, buf_data} : flash_write ?
                {3'd2, flash_page_addr} : flash_erase ? {3'd3, flash_page_addr}
                : lpm_override ? {11'h200, lpm_data} : {3'd5, 16'h0000};
            if (exp_q.size() == 0) `CHK(got, 19'h0_0000)
            else begin
                want = exp_q.pop_front();
                `CHK(got, want)
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {clock, resetn, global_interrupt_flag, eeprom_write_busy} = '0;
        pc_word = 16'h1c00;
        {fuse_low, fuse_high, fuse_ext, lock_bits} = xs();
        flash_address_pointer = 16'h0000;
        data_pair = 16'h0000;
        repeat (16) @(posedge clock);
        #2 resetn = 1'b1;
        rd(8'h00);
        cpu.op(4, 8'h00, 0, r);
        `CHK(r, 8'h00)
        repeat (2) begin
            {flash_address_pointer, data_pair} = xs();
            exp_q.push_back({3'd1, data_pair});
            wr({3'h0, CMD_FILL});
            cpu.op(2, 8'h00, 0, r);
        end
        rd(8'h00);
        exp_q.push_back({3'd5, 16'h0000});
        wr({3'h0, CMD_RWWRE});
        cpu.op(2, 8'h00, 0, r);
        p = xs() & 16'h17ff;
        flash_address_pointer = p;
        exp_q.push_back({3'd2, p & 16'hffc0});
        wr({3'h0, CMD_WRITE});
        cpu.op(2, 8'h00, 2, r);
        rd(8'h45);
        wr({3'h0, CMD_RWWRE});
        cpu.op(2, 8'h00, 0, r);
        rd(8'h00);
        p = xs() | 16'h1800;
        flash_address_pointer = p;
        exp_q.push_back({3'd3, p & 16'hffc0});
        wr({3'h0, CMD_ERASE});
        cpu.op(2, 8'h00, 0, r);
        for (int n = 0; n < 40 && cpu_halt !== 1'b0; n++) begin
            @(posedge clock);
            #2;
        end
        `CHK(cpu_halt, 1'b0)
        if (cpu_halt !== 1'b0) test_done();
        rd(8'h00);
        wr({3'h0, CMD_WRITE});
        cpu.op(2, 8'h00, 3, r);
        rd(8'h00);
        for (int i = 0; i < 4; i++) begin
            cpu.op(0, 8'h07 + 8'(i * 4), 0, r);
            cpu.op(2, 8'h00, 0, r);
        end
        pc_word = 16'h0100;
        wr({3'h0, CMD_FILL});
        cpu.op(2, 8'h00, 0, r);
        pc_word = 16'h1c00;
        for (int s = 0; s < 4; s++) begin
            flash_address_pointer = 16'(s);
            exp_q.push_back({11'h200, s == 0 ? fuse_low : s == 1 ?
                {6'h3f, lock_bits} : s == 2 ? fuse_ext : fuse_high});
            wr({3'h0, CMD_LFREAD});
            cpu.op(3, 8'h00, 1, r);
        end
        global_interrupt_flag = 1'b1;
        wr(8'h80);
        `CHK(spm_ready_irq, 1'b1)
        eeprom_write_busy = 1'b1;
        repeat (4) @(posedge clock);
        #2;
        `CHK(spm_ready_irq, 1'b0)
        wr(8'h81);
        cpu.op(2, 8'h00, 0, r);
        eeprom_write_busy = 1'b0;
        rd(8'h80);
        `CHK(exp_q.size(), 0)
        test_done();
    end
endmodule : test_flash_self_program_ctrl

/* File: src/flash_self_program_ctrl.sv */
// Purpose: Flash self-programming sequencer with control/status register
// Assumes: CPU core drives I/O strobes and spm/lpm strobes on clock
// Notes: Flash array itself sits outside; this block issues its commands
module flash_self_program_ctrl
    import spm_pkg::*;
#(
    parameter bit HAS_RWW = 1'b1,
    parameter int PAGE_WORD_BITS = 5,
    parameter int PROG_COUNT = PROG_CYCLES,
    parameter logic [15:0] HALT_START = 16'h1800,
    parameter logic [15:0] BOOT_START = 16'h1C00
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic global_interrupt_flag,
    input wire logic eeprom_write_busy,
    input wire logic spm_exec,
    input wire logic lpm_exec,
    input wire logic [15:0] pc_word,
    input wire logic [15:0] flash_address_pointer,
    input wire logic [15:0] data_pair,
    input wire logic [1:0] lock_bits,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high,
    input wire logic [7:0] fuse_ext,
    output logic lpm_override,
    output logic [7:0] lpm_data,
    output logic buf_wr,
    output logic [PAGE_WORD_BITS-1:0] buf_word,
    output logic [15:0] buf_data,
    output logic buf_clear,
    output logic flash_erase,
    output logic flash_write,
    output logic [15:0] flash_page_addr,
    output logic cpu_halt,
    output logic rww_blocked,
    output logic spm_ready_irq
);
    ////////////////////////////////////////////////////////////////////
    // Sequencer states
    // IDLE: no command held, command bits read zero
    // ARMED: command held, store/load window counting down
    // PROG: erase or write running, command bits held for polling
    // Only one command lives at a time; command bits written while busy are dropped
    typedef enum logic [1:0] {IDLE, ARMED, PROG} st_t;

    st_t state_r, state_nxt;
    logic [4:0] cmd_r, cmd_nxt;
    logic irq_en_r, irq_en_nxt;
    logic rww_busy_r, rww_busy_nxt;
    logic fill_r, fill_nxt;
    logic halt_r, halt_nxt;
    logic [2:0] win_r, win_nxt;
    logic [22:0] prog_cnt_r, prog_cnt_nxt;
    logic [15:0] page_r, page_nxt;
    logic lpm_ov_r, lpm_ov_nxt;
    logic [7:0] lpm_data_r, lpm_data_nxt;
    logic bw_r, bw_nxt, bc_r, bc_nxt, fe_r, fe_nxt, fw_r, fw_nxt;
    logic [PAGE_WORD_BITS-1:0] bword_r, bword_nxt;
    logic [15:0] bdata_r, bdata_nxt;

    logic ee_s1_r, ee_busy_r;
    logic csr_wr, cmd_ok, spm_ok, from_boot, tgt_halt;
    logic [7:0] sel_val;

    ////////////////////////////////////////////////////////////////////
    // EEPROM busy is a level from another block; synchronise it
    // Two flops, since the EEPROM writer may run from another clock
    // Costs two cycles of lag on the interrupt and on command refusal
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ee_s1_r <= 1'b0;
            ee_busy_r <= 1'b0;
        end else begin
            ee_s1_r <= eeprom_write_busy;
            ee_busy_r <= ee_s1_r;
        end
    end

    // Decode
    assign csr_wr = io_wr && (io_addr == SPM_CSR_OFFSET);
    // pattern filter
    // Bits 7 and 6 never take part in the pattern match
    assign cmd_ok = (io_wdata[4:0] == CMD_LFREAD) ||
                    (io_wdata[4:0] == CMD_RWWRE) ||
                    (io_wdata[4:0] == CMD_WRITE) ||
                    (io_wdata[4:0] == CMD_ERASE) ||
                    (io_wdata[4:0] == CMD_FILL);
    // boot inside halting section
    // Boot start sits above halt start, so boot code is never blocked
    assign from_boot = (pc_word >= BOOT_START);
    // halting target halts CPU
    // Compares word addresses only; lowest pointer bit picks a byte
    // Without read-while-write every target counts as halting
    assign tgt_halt = !HAS_RWW || (flash_address_pointer[15:1] >=
                      HALT_START[15:1]);
    assign spm_ok = spm_exec && (state_r == ARMED) && from_boot &&
                    !ee_busy_r;

    // programmed bits read zero
    // Unknown selectors read all ones, like unprogrammed bits
    always_comb begin
        unique case (flash_address_pointer)
            SEL_LOCK: sel_val = {6'h3F, lock_bits};
            SEL_FUSE_LO: sel_val = fuse_low;
            SEL_FUSE_HI: sel_val = fuse_high;
            SEL_FUSE_EXT: sel_val = fuse_ext;
            default: sel_val = 8'hFF;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Command sequencer next state
    // Defaults hold state; strobes and pulses fall back to zero
    // Control write stores the interrupt enable in every state
    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        irq_en_nxt = irq_en_r;
        rww_busy_nxt = rww_busy_r;
        fill_nxt = fill_r;
        halt_nxt = halt_r;
        win_nxt = win_r;
        prog_cnt_nxt = prog_cnt_r;
        page_nxt = page_r;
        lpm_ov_nxt = 1'b0;
        lpm_data_nxt = lpm_data_r;
        bw_nxt = 1'b0;
        bc_nxt = 1'b0;
        fe_nxt = 1'b0;
        fw_nxt = 1'b0;
        bword_nxt = bword_r;
        bdata_nxt = bdata_r;
        if (csr_wr) begin
            irq_en_nxt = io_wdata[BIT_IRQ_EN];
        end
        unique case (state_r)
            IDLE: begin
                if (csr_wr && cmd_ok && !ee_busy_r) begin
                    cmd_nxt = io_wdata[4:0];
                    win_nxt = 3'(ARM_CYCLES);
                    state_nxt = ARMED;
                end
            end
            ARMED: begin
                // Window counts 4, 3, 2, 1 on the edges after the write
                // Load readout honoured while the count is above one
                win_nxt = win_r - 3'd1;
                if (cmd_r == CMD_LFREAD && lpm_exec && !ee_busy_r &&
                        win_r > 3'(ARM_CYCLES - LPM_CYCLES)) begin
                    lpm_ov_nxt = 1'b1;
                    lpm_data_nxt = sel_val;
                    cmd_nxt = 5'h00;
                    state_nxt = IDLE;
                end else if (spm_ok) begin
                    unique case (cmd_r)
                        CMD_FILL: begin
                            // buffer fill
                            // Pointer bit 0 picks a byte; words start at 1
                            bw_nxt = 1'b1;
                            bword_nxt = flash_address_pointer
                                [PAGE_WORD_BITS:1];
                            bdata_nxt = data_pair;
                            fill_nxt = 1'b1;
                            cmd_nxt = 5'h00;
                            state_nxt = IDLE;
                        end
                        CMD_RWWRE: begin
                            // buffer clear on re-enable
                            // Clear only if words were filled since write
                            bc_nxt = fill_r;
                            fill_nxt = 1'b0;
                            rww_busy_nxt = 1'b0;
                            cmd_nxt = 5'h00;
                            state_nxt = IDLE;
                        end
                        CMD_WRITE, CMD_ERASE: begin
                            fw_nxt = (cmd_r == CMD_WRITE);
                            fe_nxt = (cmd_r == CMD_ERASE);
                            // Page latched here; pointer is free afterwards
                            if (cmd_r == CMD_WRITE) begin
                                fill_nxt = 1'b0;
                            end
                            page_nxt = {flash_address_pointer[15:
                                PAGE_WORD_BITS+1], {PAGE_WORD_BITS+1{1'b0}}};
                            halt_nxt = tgt_halt;
                            rww_busy_nxt = HAS_RWW && !tgt_halt;
                            prog_cnt_nxt = 23'(PROG_COUNT - 1);
                            state_nxt = PROG;
                        end
                        default: begin
                            cmd_nxt = 5'h00;
                            state_nxt = IDLE;
                        end
                    endcase
                end else if (win_r == 3'd1) begin
                    // enable clears on timeout
                    // Unanswered window drops the command quietly
                    cmd_nxt = 5'h00;
                    state_nxt = IDLE;
                end
            end
            PROG: begin
                // enable held during program
                // Counter loads once per operation; no early abort
                // Reset mid-operation drops the count and releases halt
                prog_cnt_nxt = prog_cnt_r - 23'd1;
                if (prog_cnt_r == 23'd0) begin
                    cmd_nxt = 5'h00;
                    halt_nxt = 1'b0;
                    state_nxt = IDLE;
                end
            end
            default: state_nxt = IDLE;
        endcase
    end


    // Register the sequencer; reset matches the control reset value
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= IDLE;
            cmd_r <= SPM_CSR_RESET[4:0];
            irq_en_r <= SPM_CSR_RESET[BIT_IRQ_EN];
            rww_busy_r <= 1'b0;
            fill_r <= 1'b0;
            halt_r <= 1'b0;
            win_r <= 3'd0;
            prog_cnt_r <= 23'd0;
            page_r <= 16'h0000;
            lpm_ov_r <= 1'b0;
            lpm_data_r <= 8'h00;
            bw_r <= 1'b0;
            bc_r <= 1'b0;
            fe_r <= 1'b0;
            fw_r <= 1'b0;
            bword_r <= '0;
            bdata_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cmd_r <= cmd_nxt;
            irq_en_r <= irq_en_nxt;
            rww_busy_r <= rww_busy_nxt;
            fill_r <= fill_nxt;
            halt_r <= halt_nxt;
            win_r <= win_nxt;
            prog_cnt_r <= prog_cnt_nxt;
            page_r <= page_nxt;
            lpm_ov_r <= lpm_ov_nxt;
            lpm_data_r <= lpm_data_nxt;
            bw_r <= bw_nxt;
            bc_r <= bc_nxt;
            fe_r <= fe_nxt;
            fw_r <= fw_nxt;
            bword_r <= bword_nxt;
            bdata_r <= bdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read and outputs
    // Reserved bit 5 and unmapped reads return zero
    always_comb begin
        io_rdata = 8'h00;
        if (io_rd && io_addr == SPM_CSR_OFFSET) begin
            io_rdata[4:0] = cmd_r;
            io_rdata[BIT_IRQ_EN] = irq_en_r;
            io_rdata[BIT_RWW_BUSY] = HAS_RWW && rww_busy_r;
        end
    end

    // quiet during EEPROM or SPM
    // Any held command carries the enable bit, so it masks the request
    assign spm_ready_irq = irq_en_r && global_interrupt_flag &&
                           !cmd_r[BIT_SPEN] && !ee_busy_r;

    // Pulse outputs come straight from flops; one clean cycle each
    // Halt and busy are levels held by the sequencer registers
    assign cpu_halt = halt_r;
    assign rww_blocked = HAS_RWW && rww_busy_r;
    assign lpm_override = lpm_ov_r;
    assign lpm_data = lpm_data_r;
    assign buf_wr = bw_r;
    assign buf_word = bword_r;
    assign buf_data = bdata_r;
    assign buf_clear = bc_r;
    assign flash_erase = fe_r;
    assign flash_write = fw_r;
    assign flash_page_addr = page_r;
endmodule : flash_self_program_ctrl

/* File: src/spm_pkg.sv */
// Purpose: Shared constants for the flash self-programming controller
// Assumes: Core clock of 40 MHz
// Notes: Register sits at its documented I/O offset
package spm_pkg;
    localparam logic [7:0] SPM_CSR_OFFSET = 8'h37;
    localparam logic [7:0] SPM_CSR_RESET = 8'h00;
    // Field positions
    localparam int BIT_IRQ_EN = 7;
    localparam int BIT_RWW_BUSY = 6;
    localparam int BIT_RWW_RE = 4;
    localparam int BIT_LFSEL = 3;
    localparam int BIT_PAGE_WRITE_CMD = 2;
    localparam int BIT_PAGE_ERASE_CMD = 1;
    localparam int BIT_SPEN = 0;
    // Accepted command patterns in the low five bits
    localparam logic [4:0] CMD_LFREAD = 5'h09;
    localparam logic [4:0] CMD_RWWRE = 5'h11;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_FILL = 5'h01;
    // Lock/fuse readout selectors
    localparam logic [15:0] SEL_FUSE_LO = 16'h0000;
    localparam logic [15:0] SEL_LOCK = 16'h0001;
    localparam logic [15:0] SEL_FUSE_EXT = 16'h0002;
    localparam logic [15:0] SEL_FUSE_HI = 16'h0003;
    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int ARM_CYCLES = 4;
    localparam int LPM_CYCLES = 3;
    localparam int PROG_MIN_US = 3700;
    localparam int PROG_MAX_US = 4500;
    // Aim at the midpoint, inside both bounds
    localparam int PROG_CYCLES =
        ((PROG_MIN_US + PROG_MAX_US) / 2) * (CLK_HZ / 1_000_000);
endpackage : spm_pkg
